//--- tdc_timer.sv
// tdc_timer: prescaler, free-running counter, capture/compare, accumulator,
// periodic interrupt and watchdog of the timing system
// assumes: pins sampled synchronous to clk_in, software bits are plain ports
`timescale 1ns/10ps
`default_nettype none

module tdc_timer
    import tdc_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // configuration
    input wire logic [1:0] main_prescale_select_in,
    input wire logic [1:0] periodic_rate_in,
    input wire logic [1:0] watchdog_rate_in,
    input wire logic ch4_is_capture_in,
    input wire tdc_acc_cfg_s acc_cfg_in,
    input wire logic [7:0] edge_select_in,
    input wire tdc_oc1_s compare_channel_one_in,
    input wire logic [15:0] compare_value_in [5],
    input wire logic [4:0] compare_write_in,
    // interrupt enables and flag clears
    input wire logic [10:0] irq_enable_in,
    input wire logic [10:0] flag_clear_in,
    input wire logic watchdog_service_in,
    // port a
    input wire logic [7:0] port_a_pins_in,
    input wire logic [7:0] gpio_out_data_in,
    input wire logic [7:0] gpio_dir_in,
    // status and results
    output logic [15:0] counter_out,
    output logic [15:0] capture_out [4],
    output logic [7:0] accumulator_out,
    output logic [10:0] flag_out,
    output logic [10:0] irq_out,
    output logic [7:0] port_a_data_out,
    output logic [7:0] port_a_drive_out,
    output logic [7:0] port_a_oe_b_out,
    output logic watchdog_reset_b_out
);
    // ************************************************************
    // prescaler and divider chain
    // ************************************************************
    logic [3:0] pre_q;
    logic tick;
    logic [TDC_CHAIN_W-1:0] chain_q;
    logic [TDC_CHAIN_W-1:0] chain_d;

    function automatic logic [3:0] pre_mask(input logic [1:0] sel);
        case (sel)
            2'h0: pre_mask = 4'h0;
            2'h1: pre_mask = 4'h3;
            2'h2: pre_mask = 4'h7;
            default: pre_mask = 4'hF;
        endcase
    endfunction

    assign tick = ((pre_q & pre_mask(main_prescale_select_in)) ==
                   pre_mask(main_prescale_select_in));
    assign chain_d = chain_q + 24'h000001;

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            pre_q <= 4'h0;
            chain_q <= '0;
        end
        else
        begin
            pre_q <= pre_q + 4'h1;
            chain_q <= chain_d;
        end
    end

    // ************************************************************
    // free-running counter
    // ************************************************************
    logic [15:0] cnt_q;
    logic wrap;
    assign wrap = tick && (cnt_q == TDC_CNT_MAX);

    // no load or halt input exists by design
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
            cnt_q <= TDC_CNT_RST;
        else if (tick)
            cnt_q <= cnt_q + 16'h0001;
    end
    assign counter_out = cnt_q;

    // ************************************************************
    // input capture
    // ************************************************************
    logic [3:0] pin_q;
    logic [3:0] cap_hit;
    logic [15:0] cap_q [4];

    function automatic logic edge_hit(input logic [1:0] sel,
                                      input logic prev,
                                      input logic now);
        case (sel)
            2'h1: edge_hit = !prev && now;
            2'h2: edge_hit = prev && !now;
            2'h3: edge_hit = prev != now;
            default: edge_hit = 1'b0;
        endcase
    endfunction

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
            pin_q <= 4'h0;
        else
            pin_q <= port_a_pins_in[3:0];
    end

    // captures sample the counter before its update: stable value
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_cap
            assign cap_hit[gi] = edge_hit(edge_select_in[2*gi +: 2],
                pin_q[gi], port_a_pins_in[gi]) &&
                ((gi != 3) || ch4_is_capture_in);
            always_ff @(posedge clk_in)
            begin
                if (!rst_b_in)
                    cap_q[gi] <= TDC_CNT_RST;
                else if (cap_hit[gi])
                    cap_q[gi] <= cnt_q;
            end
            assign capture_out[gi] = cap_q[gi];
        end
    endgenerate

    // ************************************************************
    // output compare
    // ************************************************************
    logic [15:0] cmp_q [5];
    logic [4:0] cmp_hit;
    logic [7:0] pin_drv_q;

    generate
        for (gi = 0; gi < 5; gi++)
        begin : g_cmp
            always_ff @(posedge clk_in)
            begin
                if (!rst_b_in)
                    cmp_q[gi] <= TDC_CMP_RST;
                else if (compare_write_in[gi])
                    cmp_q[gi] <= compare_value_in[gi];
            end
            assign cmp_hit[gi] = tick && (cmp_q[gi] == cnt_q) &&
                ((gi != 4) || !ch4_is_capture_in);
        end
    endgenerate

    // channel index 0 is channel one; 1..4 are channels two to five
    logic [4:0] cmp_owned;
    assign cmp_owned = {!ch4_is_capture_in, 3'h7, 1'b0} |
                       {compare_channel_one_in.mask[0],
                        compare_channel_one_in.mask[1],
                        compare_channel_one_in.mask[2],
                        compare_channel_one_in.mask[3], 1'b0};

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
            pin_drv_q <= 8'h00;
        else
        begin
            for (int b = 0; b < 8; b++)
            begin
                if (b >= TDC_PIN_CMP_LO && cmp_hit[0] &&
                    compare_channel_one_in.mask[b-TDC_PIN_CMP_LO])
                    pin_drv_q[b] <= compare_channel_one_in.data[
                        b-TDC_PIN_CMP_LO];
                else if (b >= 3 && b <= 6 && cmp_hit[7-b])
                    pin_drv_q[b] <= !pin_drv_q[b];
                else if (!(b >= 3 && b <= 6 && cmp_owned[7-b]) &&
                         !(b == 7 && compare_channel_one_in.mask[4]))
                    pin_drv_q[b] <= gpio_out_data_in[b];
            end
        end
    end
    assign port_a_drive_out = pin_drv_q;

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
            port_a_oe_b_out <= 8'hFF;
        else
            port_a_oe_b_out <= ~(gpio_dir_in |
                {compare_channel_one_in.mask[4], cmp_owned[1],
                 cmp_owned[2], cmp_owned[3], cmp_owned[4], 3'h0});
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
            port_a_data_out <= 8'h00;
        else
            port_a_data_out <= port_a_pins_in;
    end

    // ************************************************************
    // pulse accumulator
    // ************************************************************
    logic acc_pin_q;
    logic [7:0] acc_q;
    logic acc_step;
    logic gate_tick;

    assign gate_tick = chain_q[TDC_GATE_TAP-1:0] == '1;
    assign acc_step = acc_cfg_in.enable && (acc_cfg_in.gated_mode ?
        (gate_tick && port_a_pins_in[TDC_PIN_ACC] ==
            acc_cfg_in.edge_or_level) :
        (acc_pin_q != port_a_pins_in[TDC_PIN_ACC] &&
            port_a_pins_in[TDC_PIN_ACC] == acc_cfg_in.edge_or_level));

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            acc_pin_q <= 1'b0;
            acc_q <= TDC_ACC_RST;
        end
        else
        begin
            acc_pin_q <= port_a_pins_in[TDC_PIN_ACC];
            if (acc_step)
                acc_q <= acc_q + 8'h01;
        end
    end
    assign accumulator_out = acc_q;

    // ************************************************************
    // periodic interrupt tick
    // ************************************************************
    logic periodic_hit;
    assign periodic_hit = chain_q[TDC_PERIODIC_TAP + periodic_rate_in -: 1]
        == 1'b1 && chain_d[TDC_PERIODIC_TAP + periodic_rate_in] == 1'b0;

    // ************************************************************
    // flags: 0..3 capture, 4..8 compare, 9 overflow, 10 periodic
    // ************************************************************
    logic [10:0] set_ev;
    logic [10:0] flag_q;
    assign set_ev = {periodic_hit, wrap, cmp_hit, cap_hit};

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            flag_q <= 11'h000;
            irq_out <= 11'h000;
        end
        else
        begin
            // set wins over a same-cycle clear
            flag_q <= (flag_q & ~flag_clear_in) | set_ev;
            irq_out <= ((flag_q & ~flag_clear_in) | set_ev) &
                       irq_enable_in;
        end
    end
    assign flag_out = flag_q;

    // ************************************************************
    // watchdog
    // ************************************************************
    tdc_dog_e dog_q;
    logic [3:0] dog_cnt_q;
    logic dog_tick;
    assign dog_tick = chain_q[TDC_DOG_TAP-1:0] == '1;

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            dog_q <= TDC_DOG_ARMED;
            dog_cnt_q <= 4'h0;
            watchdog_reset_b_out <= 1'b1;
        end
        else
        begin
            case (dog_q)
                TDC_DOG_ARMED:
                begin
                    watchdog_reset_b_out <= 1'b1;
                    if (watchdog_service_in)
                        dog_cnt_q <= 4'h0;
                    else if (dog_tick)
                    begin
                        dog_cnt_q <= dog_cnt_q + 4'h1;
                        if (dog_cnt_q[2:0] == ({1'b0, watchdog_rate_in}
                            & TDC_DOG_LIMIT_RST))
                            dog_q <= TDC_DOG_FIRE;
                    end
                end
                TDC_DOG_FIRE:
                begin
                    watchdog_reset_b_out <= 1'b0;
                    dog_cnt_q <= 4'h0;
                    dog_q <= TDC_DOG_IDLE;
                end
                TDC_DOG_IDLE:
                begin
                    watchdog_reset_b_out <= 1'b0;
                    dog_q <= TDC_DOG_ARMED;
                end
                default: dog_q <= TDC_DOG_ARMED;
            endcase
        end
    end
endmodule // tdc_timer

`default_nettype wire

//--- tdc_pkg.sv
// tdc_pkg: constants, enums and carrier structs of the timer divider chain
// assumes: one 125 MHz clock, all control bits delivered as plain ports
package tdc_pkg;
    // ************************************************************
    // widths and reset values
    // ************************************************************
    localparam int TDC_CNT_W = 16;
    localparam int TDC_ACC_W = 8;
    localparam int TDC_NUM_IC = 3;
    localparam int TDC_NUM_OC = 4;
    localparam logic [15:0] TDC_CNT_RST = 16'h0000;
    localparam logic [15:0] TDC_CNT_MAX = 16'hFFFF;
    localparam logic [15:0] TDC_CMP_RST = 16'hFFFF;
    localparam logic [7:0] TDC_ACC_RST = 8'h00;
    // ************************************************************
    // divider chain taps
    // ************************************************************
    localparam int TDC_CHAIN_W = 24;
    localparam int TDC_DOG_TAP = 15;
    localparam int TDC_GATE_TAP = 6;
    localparam int TDC_PERIODIC_TAP = 13;
    localparam logic [2:0] TDC_DOG_LIMIT_RST = 3'h7;
    // ************************************************************
    // pin positions in port a
    // ************************************************************
    localparam int TDC_PIN_CMP_LO = 3;
    localparam int TDC_PIN_ACC = 7;

    typedef enum logic [1:0] {
        TDC_EDGE_OFF,
        TDC_EDGE_RISE,
        TDC_EDGE_FALL,
        TDC_EDGE_ANY
    } tdc_edge_e;

    typedef enum logic [1:0] {
        TDC_DOG_IDLE,
        TDC_DOG_ARMED,
        TDC_DOG_FIRE
    } tdc_dog_e;

    // channel one compare action
    typedef struct packed {
        logic [4:0] mask;
        logic [4:0] data;
    } tdc_oc1_s;

    // pulse accumulator setup
    typedef struct packed {
        logic enable;
        logic gated_mode;
        logic edge_or_level;
    } tdc_acc_cfg_s;
endpackage : tdc_pkg

//--- tdc_timer_props.sv
// tdc_timer_props: concurrent checks on the timer ports
// assumes: bound to tdc_timer, single clock domain
`timescale 1ns/10ps
`default_nettype none
module tdc_props
    import tdc_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // controls and pins
    input wire logic [1:0] main_prescale_select_in,
    input wire logic [7:0] edge_select_in,
    input wire logic [10:0] irq_enable_in,
    input wire logic [10:0] flag_clear_in,
    input wire logic [7:0] port_a_pins_in,
    // results
    input wire logic [15:0] counter_out,
    input wire logic [15:0] capture_out [4],
    input wire logic [10:0] flag_out,
    input wire logic [10:0] irq_out,
    input wire logic [7:0] port_a_data_out,
    input wire logic watchdog_reset_b_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    // **********
    // counter
    // **********
    step_one_a: assert property ($past(rst_b_in) && $past(rst_b_in, 2)
        && main_prescale_select_in == 2'h0
        && $past(main_prescale_select_in) == 2'h0
        && $past(main_prescale_select_in, 2) == 2'h0
        |-> counter_out == $past(counter_out) + 16'h0001)
        else $error("counter not stepping every clock");
    only_up_a: assert property ($past(rst_b_in)
        && counter_out != $past(counter_out)
        |-> counter_out == $past(counter_out) + 16'h0001)
        else $error("counter moved other than by one");
    wrap_flag_a: assert property ($past(rst_b_in)
        && $past(counter_out) == 16'hFFFF && counter_out == 16'h0000
        |-> ##[0:1] flag_out[9])
        else $error("wrap without overflow flag");
    flag_hold_a: assert property ($past(rst_b_in) && $past(flag_out[9])
        && !$past(flag_clear_in[9]) |-> flag_out[9])
        else $error("overflow flag dropped without clear");
    irq_mask_a: assert property (!irq_enable_in[9]
        && !$past(irq_enable_in[9]) |-> !irq_out[9])
        else $error("overflow request while disabled");
    irq_raise_a: assert property ((flag_out[9] && irq_enable_in[9])[*2]
        |-> irq_out[9])
        else $error("overflow request missing");
    // **********
    // pins, capture and watchdog
    // **********
    pin_echo_a: assert property ($past(rst_b_in)
        |-> port_a_data_out[3:0] == $past(port_a_pins_in[3:0]))
        else $error("port data not following pins");
    cap_rise_a: assert property ($past(rst_b_in)
        && edge_select_in[1:0] == 2'h1 && $stable(edge_select_in)
        && $rose(port_a_pins_in[0])
        |=> capture_out[0] == $past(counter_out) && flag_out[0])
        else $error("rising edge capture wrong");
    cap_off_a: assert property ($past(edge_select_in[1:0]) == 2'h0
        |-> $stable(capture_out[0]))
        else $error("capture while disabled");
    dog_pulse_a: assert property ($fell(watchdog_reset_b_out)
        |=> !watchdog_reset_b_out ##1 watchdog_reset_b_out)
        else $error("watchdog reset pulse width");
endmodule // tdc_props

bind tdc_timer tdc_props props_u (
    .clk_in,
    .rst_b_in,
    .main_prescale_select_in,
    .edge_select_in,
    .irq_enable_in,
    .flag_clear_in,
    .port_a_pins_in,
    .counter_out,
    .capture_out,
    .flag_out,
    .irq_out,
    .port_a_data_out,
    .watchdog_reset_b_out
);
`default_nettype wire

//--- tdc_pins.sv
// tdc_pins: outside world on port a, external levels and timer drive
// assumes: bench sets levels, timer output enables are active low
`timescale 1ns/10ps
`default_nettype none
module tdc_pins
    import tdc_pkg::*;
(
    // external levels and timer drive
    input wire logic [7:0] level_in,
    input wire logic [7:0] drive_in,
    input wire logic [7:0] oe_b_in,
    // resolved pins
    output logic [7:0] pins_out
);
    // bench moves levels on the falling edge, clear of the sampling edge
    assign pins_out = (level_in & oe_b_in) | (drive_in & ~oe_b_in);
endmodule // tdc_pins
`default_nettype wire

//--- testbench.sv
// testbench: directed checks of the timer divider chain
// assumes: 125 MHz clock, inputs change on the falling edge
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import tdc_pkg::*;
    logic clk_in, rst_b_in, ch4, svc;
    logic [1:0] psel, prate, drate;
    logic [7:0] esel, lvl, gdat, gdir, pins, pdat, drv, oeb, accv;
    logic [10:0] ien, fclr, flg, irq;
    logic [4:0] cwr;
    logic [15:0] cval [5];
    logic [15:0] cap [4];
    logic [15:0] cnt, c;
    logic wdb;
    tdc_acc_cfg_s acc;
    tdc_oc1_s oc1;
    int err_total, num_checks, cyc, n, wd;
    int div [4] = '{1, 4, 8, 16};

    tdc_timer dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .main_prescale_select_in(psel), .periodic_rate_in(prate),
        .watchdog_rate_in(drate), .ch4_is_capture_in(ch4),
        .acc_cfg_in(acc), .edge_select_in(esel),
        .compare_channel_one_in(oc1), .compare_value_in(cval),
        .compare_write_in(cwr), .irq_enable_in(ien), .flag_clear_in(fclr),
        .watchdog_service_in(svc), .port_a_pins_in(pins),
        .gpio_out_data_in(gdat), .gpio_dir_in(gdir), .counter_out(cnt),
        .capture_out(cap), .accumulator_out(accv), .flag_out(flg),
        .irq_out(irq), .port_a_data_out(pdat), .port_a_drive_out(drv),
        .port_a_oe_b_out(oeb), .watchdog_reset_b_out(wdb));
    tdc_pins pins_u (.level_in(lvl), .drive_in(drv),
        .oe_b_in(oeb), .pins_out(pins));

    task automatic check(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        if (err_total == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(negedge clk_in);
    endtask
    task automatic clr(input int i);
        fclr[i] = 1'b1;
        tick(1);
        fclr = 11'h000;
    endtask
    task automatic step();
        tick(1);
        n++;
        if (wdb === 1'b0 && wd == 0)
            wd = n;
    endtask

    initial
    begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    // hang guard: whole run needs about 82000 cycles
    always @(posedge clk_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 95000)
        begin
            err_total++;
            tally_and_finish();
        end
    end

    initial
    begin
        {rst_b_in, ch4, svc, psel, prate, drate, esel, lvl} = '0;
        {gdat, gdir, ien, fclr, cwr, acc, oc1} = '0;
        {err_total, num_checks, cyc, n, wd} = '0;
        foreach (cval[i]) cval[i] = 16'hFFFF;
        drate = 2'h1;
        ch4 = 1'b1;
        tick(12);
        rst_b_in = 1'b1;
        check("count start", cnt, 16'h0000);
        tick(1);
        check("count next", cnt, 16'h0001);
        for (int s = 0; s < 4; s++)
        begin
            psel = s[1:0];
            tick(20);
            c = cnt;
            while (cnt === c) tick(1);
            c = cnt;
            n = 0;
            while (cnt === c) step();
            check("prescale", 16'(n), 16'(div[s]));
        end
        psel = 2'h0;
        // every channel through every edge code, rise then fall
        for (int ch = 0; ch < 4; ch++)
            for (int e = 0; e < 4; e++)
            begin
                esel = 8'(e) << (2 * ch);
                tick(2);
                clr(ch);
                lvl[ch] = 1'b1;
                tick(3);
                check("capture rise", 16'(flg[ch]), 16'(e % 2));
                clr(ch);
                lvl[ch] = 1'b0;
                tick(3);
                check("capture fall", 16'(flg[ch]), 16'(e / 2));
            end
        esel = 8'h00;
        lvl[3:0] = 4'hA;
        tick(3);
        check("live pins", 16'(pdat[3:0]), 16'h000A);
        acc = '{enable: 1'b1, gated_mode: 1'b0, edge_or_level: 1'b1};
        repeat (3)
        begin
            tick(3);
            lvl[7] = 1'b1;
            tick(3);
            lvl[7] = 1'b0;
        end
        tick(3);
        check("event count", 16'(accv), 16'h0003);
        svc = 1'b1;
        tick(1);
        svc = 1'b0;
        n = 0;
        wd = 0;
        while (cnt !== 16'hFFFF) step();
        step();
        step();
        check("overflow flag", 16'(flg[9]), 16'h0001);
        check("masked request", 16'(irq[9]), 16'h0000);
        ien[9] = 1'b1;
        step();
        step();
        check("overflow request", 16'(irq[9]), 16'h0001);
        clr(9);
        step();
        check("flag cleared", 16'(flg[9]), 16'h0000);
        while (wd == 0 && n < 70000) step();
        // two ticks of 2^15 clocks, tick phase unknown after service
        check("watchdog time", 16'(wd >= 32768 && wd <= 65540),
            16'h0001);
        // 640 clocks at level one span exactly ten gate ticks
        acc = '{enable: 1'b1, gated_mode: 1'b1, edge_or_level: 1'b1};
        lvl[7] = 1'b1;
        tick(640);
        lvl[7] = 1'b0;
        tick(2);
        check("gated count", 16'(accv), 16'h000D);
        acc = '0;
        // channel one owns pins 3 and 7, channel two toggles pin 6
        oc1 = '{mask: 5'h11, data: 5'h11};
        gdat = 8'h01;
        ien[4] = 1'b1;
        c = cnt + 16'h0010;
        cval[0] = c;
        cval[1] = c;
        cwr = 5'h03;
        fclr = 11'h030;
        tick(1);
        cwr = 5'h00;
        fclr = 11'h000;
        n = int'(drv[6]);
        while (cnt !== c) tick(1);
        tick(2);
        check("one drives pin", 16'(drv[3]), 16'h0001);
        check("one drives pin seven", 16'(drv[7]), 16'h0001);
        check("two toggles pin", 16'(drv[6]), 16'(n == 0));
        check("owned enables", 16'(oeb), 16'h0007);
        check("gpio pin", 16'(drv[0]), 16'h0001);
        check("compare flags", 16'(flg[5:4]), 16'h0003);
        check("compare request", 16'(irq[4]), 16'h0001);
        // periodic tick at rate zero returns within 2^14 clocks
        clr(10);
        n = 0;
        while (flg[10] !== 1'b1 && n < 17000) step();
        check("periodic pace", 16'(n <= 16384), 16'h0001);
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
